/* bench/qlsd_host.sv */
// serial host model for the mode controller
// assumes: serial clock of 8 system clocks, idle low between frames
`timescale 1ns/1ps
`default_nettype none
module qlsd_host (
  // system clock for pacing
  input wire logic  clock,
  // serial link
  output logic      chip_select_low,
  output logic      serial_clock,
  output logic      serial_in,
  input wire logic  serial_out_q,
  input wire logic  serial_out_oe_q
);
  initial begin
    chip_select_low = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // msb first, one bit per serial clock period
  task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge clock);
    #1 chip_select_low = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = tx[i];
      repeat (4) @(posedge clock);
      #1 serial_clock = 1'b1;
      // a released line shows the inverse so a float is caught
      rx = {rx[30:0], serial_out_oe_q ? serial_out_q : ~serial_out_q};
      repeat (4) @(posedge clock);
      #1 serial_clock = 1'b0;
    end
    repeat (4) @(posedge clock);
    #1 chip_select_low = 1'b1;
    serial_in = ~serial_in;
    repeat (8) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

/* bench/qlsd_mode_ctrl_asserts.sv */
// checker for the quad low-side mode controller
// assumes: bound to qlsd_mode_ctrl, four channels
`timescale 1ns/1ps
`default_nettype none
module qlsd_mode_ctrl_chk #(
  parameter int FILT_CYC = 4
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // pins
  input wire logic       logic_supply_por,
  input wire logic       analog_supply_por,
  input wire logic       enable_in,
  input wire logic       limp_home_input,
  input wire logic [3:0] parallel_drive_inputs,
  input wire logic [3:0] overload_detect,
  input wire logic       chip_select_low,
  // outputs
  input wire logic       serial_out_oe_q,
  input wire logic [3:0] lowside_outputs,
  input wire logic [3:0] diag_current_en,
  input wire logic       lockout_state,
  input wire logic       limp_home_state,
  input wire logic       reduced_quiescent_state,
  input wire logic       frame_error_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // run length of overload on channel 0
  logic [7:0] ovl_run_q;
  always_ff @(posedge clock) begin
    if (rst || !overload_detect[0]) ovl_run_q <= 8'h00;
    else if (ovl_run_q != 8'hFF) ovl_run_q <= ovl_run_q + 8'h01;
  end
  // ==========
  a_oe_release: assert property (chip_select_low [*6] |-> !serial_out_oe_q)
    else $error("serial out driven while deselected");
  a_oe_drive: assert property ($fell(chip_select_low) |-> ##[2:4] serial_out_oe_q)
    else $error("serial out not driven after select");
  a_lockout_off: assert property (lockout_state |-> lowside_outputs == 4'h0)
    else $error("output on in lockout");
  a_analog_lock: assert property (analog_supply_por [*5] |-> lockout_state)
    else $error("no lockout under analog reset");
  a_limp_follow: assert property (
    (limp_home_state && $stable(parallel_drive_inputs)) [*5]
    |-> lowside_outputs[3:1] == parallel_drive_inputs[3:1])
    else $error("limp home outputs do not follow inputs");
  a_overload_trip: assert property (int'(ovl_run_q) > FILT_CYC + 5 |-> !lowside_outputs[0])
    else $error("overload did not switch channel off");
  a_enable_reload: assert property (
    $rose(enable_in) && !analog_supply_por && !logic_supply_por
    && !limp_home_input |-> ##[1:8] (frame_error_flag && lowside_outputs == 4'h0
    && diag_current_en == 4'h0))
    else $error("enable edge did not reload defaults");
  a_diag_only_off: assert property ((diag_current_en & lowside_outputs) == 4'h0)
    else $error("diagnostic current on a driven channel");
  a_standby_quiet: assert property (reduced_quiescent_state |-> lowside_outputs == 4'h0
    && diag_current_en == 4'h0)
    else $error("standby not quiet");
  c_limp: cover property ($rose(limp_home_state));
  c_standby: cover property ($rose(reduced_quiescent_state));
  c_trip: cover property ($fell(lowside_outputs[0]) && overload_detect[0]);
endmodule
bind qlsd_mode_ctrl qlsd_mode_ctrl_chk #(.FILT_CYC(FILT_CYC)) u_chk (.clock, .rst,
  .logic_supply_por, .analog_supply_por, .enable_in, .limp_home_input,
  .parallel_drive_inputs, .overload_detect, .chip_select_low, .serial_out_oe_q,
  .lowside_outputs, .diag_current_en, .lockout_state, .limp_home_state,
  .reduced_quiescent_state, .frame_error_flag);
`default_nettype wire

/* bench/tb.sv */
// testbench for the quad low-side mode controller
// assumes: qlsd_host drives the link, short overload filter
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FILT = 4;
  logic clock, rst, logic_supply_por, analog_supply_por, enable_in, limp_home_input;
  logic [3:0] parallel_drive_inputs, overload_detect, overtemp_detect, open_load_detect;
  wire chip_select_low, serial_clock, serial_in, serial_out_q, serial_out_oe_q;
  wire [3:0] lowside_outputs, diag_current_en;
  wire lockout_state, limp_home_state, lowest_quiescent_state;
  wire reduced_quiescent_state, frame_error_flag;
  int error_cnt = 0;
  int checked = 0;
  int lens[3] = '{12, 8, 24};
  logic [31:0] rx;

  qlsd_mode_ctrl #(.FILT_CYC(FILT)) dut (.clock, .rst, .logic_supply_por,
    .analog_supply_por, .enable_in, .limp_home_input, .parallel_drive_inputs,
    .overload_detect, .overtemp_detect, .open_load_detect, .chip_select_low,
    .serial_clock, .serial_in, .serial_out_q, .serial_out_oe_q, .lowside_outputs,
    .diag_current_en, .lockout_state, .limp_home_state, .lowest_quiescent_state,
    .reduced_quiescent_state, .frame_error_flag);
  qlsd_host host (.clock, .chip_select_low, .serial_clock, .serial_in,
    .serial_out_q, .serial_out_oe_q);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic frame(input int n, input logic [31:0] tx);
    host.xfer(n, tx, rx);
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========
  initial begin
    #2ms;
    error_cnt++;
    finish_test();
  end
  initial begin
    rst = 1'b1; logic_supply_por = 1'b1; analog_supply_por = 1'b1;
    enable_in = 1'b0; limp_home_input = 1'b0; parallel_drive_inputs = 4'h0;
    overload_detect = 4'h0; overtemp_detect = 4'h0; open_load_detect = 4'h0;
    tick(10);
    rst = 1'b0;
    tick(4);
    check(lockout_state, 1'b1);
    logic_supply_por = 1'b0;
    tick(6);
    check(lockout_state, 1'b1);
    analog_supply_por = 1'b0;
    tick(6);
    check(lowest_quiescent_state, 1'b1);
    frame(16, 16'hAAAA);
    check(lowside_outputs, 4'h0);
    enable_in = 1'b1;
    tick(8);
    check({frame_error_flag, diag_current_en, lowside_outputs}, 9'h100);
    frame(16, 16'hAAAA);
    check(rx[15:0], 16'h8000);
    check({frame_error_flag, lowside_outputs}, 5'h0F);
    // ch3 off, ch2 on, ch1 input, ch0 standby
    parallel_drive_inputs = 4'hF;
    frame(16, 16'h00E4);
    check(lowside_outputs, 4'h6);
    check(diag_current_en, 4'h8);
    parallel_drive_inputs = 4'h9;
    tick(6);
    check(lowside_outputs, 4'h4);
    foreach (lens[i]) begin
      frame(lens[i], 32'h00FFAAAA);
      check(frame_error_flag, lens[i] != 24);
      check(lowside_outputs, lens[i] == 24 ? 4'hF : 4'h4);
    end
    // spike shorter than the filter must not trip
    overload_detect = 4'h1;
    tick(2);
    overload_detect = 4'h0;
    tick(8);
    check(lowside_outputs, 4'hF);
    overload_detect = 4'h1;
    tick(FILT + 8);
    overload_detect = 4'h0;
    tick(4);
    check(lowside_outputs, 4'hE);
    frame(16, 16'hAAAA);
    check(rx[15:0], 16'h0002);
    check(lowside_outputs, 4'hE);
    frame(16, 16'hAAA8);
    frame(16, 16'hAAAA);
    check(lowside_outputs, 4'hF);
    overtemp_detect = 4'h4;
    tick(8);
    overtemp_detect = 4'h0;
    tick(4);
    check(lowside_outputs, 4'hB);
    frame(16, 16'hAAAA);
    check(rx[15:0], 16'h0030);
    frame(16, 16'h0000);
    check({reduced_quiescent_state, diag_current_en, lowside_outputs}, 9'h100);
    open_load_detect = 4'h2;
    frame(16, 16'hFFFF);
    check(rx[15:0], 16'h0004);
    open_load_detect = 4'h0;
    check({reduced_quiescent_state, diag_current_en, lowside_outputs}, 9'h0F0);
    parallel_drive_inputs = 4'h5;
    limp_home_input = 1'b1;
    tick(8);
    check({limp_home_state, lowside_outputs}, 5'h15);
    logic_supply_por = 1'b1;
    tick(6);
    check({limp_home_state, lockout_state, lowside_outputs}, 6'h25);
    logic_supply_por = 1'b0;
    frame(16, 16'hAAAA);
    check(lowside_outputs, 4'h5);
    overload_detect = 4'h1;
    tick(FILT + 8);
    overload_detect = 4'h0;
    tick(4);
    check(lowside_outputs, 4'h4);
    frame(16, 16'hAAAA);
    check(rx[1:0], 2'h2);
    limp_home_input = 1'b0;
    tick(8);
    check({limp_home_state, frame_error_flag, diag_current_en, lowside_outputs}, 10'h100);
    frame(16, 16'hAAAA);
    check(rx[15:0], 16'h8000);
    enable_in = 1'b0;
    tick(8);
    check({lowest_quiescent_state, lowside_outputs}, 5'h10);
    enable_in = 1'b1;
    tick(8);
    check({frame_error_flag, lowside_outputs}, 5'h10);
    frame(16, 16'hAAAA);
    check(lowside_outputs, 4'hF);
    analog_supply_por = 1'b1;
    tick(6);
    check({lockout_state, lowside_outputs}, 5'h10);
    analog_supply_por = 1'b0;
    tick(8);
    check({lockout_state, frame_error_flag, diag_current_en}, 6'h10);
    finish_test();
  end
endmodule
`default_nettype wire

/* shared/qlsd_defines.vh */
// qlsd_defines.vh: constants for the quad low-side mode controller
// assumes: included by bare name from design files under src/
`ifndef QLSD_DEFINES_VH
`define QLSD_DEFINES_VH

// ==========================================================
// channel command codes
`define QLSD_CMD_STBY      2'h0
`define QLSD_CMD_INPUT     2'h1
`define QLSD_CMD_ON        2'h2
`define QLSD_CMD_OFF       2'h3

// ==========================================================
// frame layout
`define QLSD_FRAME_BITS    16
`define QLSD_WORD_BITS     8
`define QLSD_CMD_RESET     16'hFFFF
`define QLSD_CNT_W         6

// ==========================================================
// timing
`define QLSD_CLK_NS        50
`define QLSD_OVL_MIN_NS    3000
`define QLSD_OVL_CYC       ((`QLSD_OVL_MIN_NS + `QLSD_CLK_NS - 1) / `QLSD_CLK_NS)
`define QLSD_FILT_W        8

`endif

/* src/qlsd_fault_filter.v */
// qlsd_fault_filter.v: per-channel overload filter and fault latch
// assumes: overload and thermal flags already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
`include "qlsd_defines.vh"

module qlsd_fault_filter #(
  parameter FILT_CYC = `QLSD_OVL_CYC
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // fault sources and clear
  input  wire       overload,
  input  wire       overtemp,
  input  wire       clear,
  // latched state
  output reg        ovl_latch_q,
  output reg        otp_latch_q
);

  reg [`QLSD_FILT_W-1:0] cnt_q;

  // ==========================================================
  // spike filter, counts only while overload persists
  always @(posedge clock) begin
    if (rst || !overload) begin
      cnt_q <= {`QLSD_FILT_W{1'b0}};
    end else if (cnt_q != FILT_CYC[`QLSD_FILT_W-1:0]) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // latches; a new event beats a clear in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      ovl_latch_q <= 1'b0;
      otp_latch_q <= 1'b0;
    end else begin
      if (overload && cnt_q == FILT_CYC[`QLSD_FILT_W-1:0]) begin
        ovl_latch_q <= 1'b1;
      end else if (clear) begin
        ovl_latch_q <= 1'b0;
      end
      if (overtemp) begin
        otp_latch_q <= 1'b1;
      end else if (clear) begin
        otp_latch_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* src/qlsd_mode_ctrl.v */
// qlsd_mode_ctrl.v: mode, serial link and fault control of a four-channel low-side driver
// assumes: all pin inputs asynchronous to clock; serial clock well below clock/4
//
// Functional notes
// - overload switches channel off and latches it until cleared.
// - overload shorter than minimum delay does not trip the latch.
// - faults cleared by standby command, power-on reset, or leaving limp home.
// - fault detection active while turning on and while on.
// - serial commands accepted only out of reset and with enable high.
// - each enable rising edge outside limp home reloads all defaults.
// - each channel independently selects standby, input, on or off.
// - after reset commands all ones, status zero, frame error flag one.
// - both supply resets needed; in limp home only analog reset acts.
// - power-up global off without diagnostic current; other entries enable it.
// - analog supply reset, and logic supply reset outside limp home, hold all outputs off.
// - leaving lockout gives off without diagnostics, or limp home if input high.
// - code 11 output off, code 10 output on.
// - code 11 on all channels is global off.
// - code 00 standby, no diagnostics; all channels gives reduced quiescent state.
// - code 01 output follows its own parallel input.
// - limp home drives outputs one to four from inputs one to four.
// - enable and limp home both low give lowest quiescent state.
// - limp home input governs how parallel inputs act on outputs.
// - serial output driven only while chip select low.
// - sixteen-bit frames, msb first, two bits per channel each way.
// - bit count not multiple of eight or below sixteen sets frame error.
// - limp home ignores commands but faults stay readable.
// - overtemperature latches only its own channel off.
`timescale 1ns/1ps
`default_nettype none
`include "qlsd_defines.vh"

module qlsd_mode_ctrl #(
  parameter NCH      = 4,
  parameter FILT_CYC = `QLSD_OVL_CYC
) (
  // clock and reset
  input  wire           clock,
  input  wire           rst,
  // supplies, enable, limp home (asynchronous)
  input  wire           logic_supply_por,
  input  wire           analog_supply_por,
  input  wire           enable_in,
  input  wire           limp_home_input,
  // parallel inputs and analog fault flags (asynchronous)
  input  wire [NCH-1:0] parallel_drive_inputs,
  input  wire [NCH-1:0] overload_detect,
  input  wire [NCH-1:0] overtemp_detect,
  input  wire [NCH-1:0] open_load_detect,
  // serial link (asynchronous)
  input  wire           chip_select_low,
  input  wire           serial_clock,
  input  wire           serial_in,
  output reg            serial_out_q,
  output reg            serial_out_oe_q,
  // driver controls
  output reg  [NCH-1:0] lowside_outputs,
  output reg  [NCH-1:0] diag_current_en,
  output reg            lockout_state,
  output reg            limp_home_state,
  output reg            lowest_quiescent_state,
  output reg            reduced_quiescent_state,
  output reg            frame_error_flag
);

  localparam NSYNC = 7 + 3 * NCH;
  localparam ST_UVLO  = 2'h0;
  localparam ST_LOWIQ = 2'h1;
  localparam ST_RUN   = 2'h2;
  localparam ST_LIMP  = 2'h3;

  // ==========================================================
  // two-flop synchronisers
  wire [NSYNC-1:0] raw = {logic_supply_por, analog_supply_por, enable_in,
                          limp_home_input, chip_select_low, serial_clock,
                          serial_in, parallel_drive_inputs, overload_detect,
                          overtemp_detect};
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  always @(posedge clock) begin
    s1_q <= raw;
    s2_q <= s1_q;
  end
  wire           por_l  = s2_q[NSYNC-1];
  wire           por_a  = s2_q[NSYNC-2];
  wire           en_s   = s2_q[NSYNC-3];
  wire           limp_s   = s2_q[NSYNC-4];
  wire           cs_low_s = s2_q[NSYNC-5];
  wire           sck_s  = s2_q[NSYNC-6];
  wire           si_s   = s2_q[NSYNC-7];
  wire [NCH-1:0] in_s   = s2_q[3*NCH-1:2*NCH];
  wire [NCH-1:0] ovl_s  = s2_q[2*NCH-1:NCH];
  wire [NCH-1:0] otp_s  = s2_q[NCH-1:0];
  reg  [NCH-1:0] ol_s1_q;
  reg  [NCH-1:0] ol_s2_q;
  always @(posedge clock) begin
    ol_s1_q <= open_load_detect;
    ol_s2_q <= ol_s1_q;
  end

  // ==========================================================
  // edge history
  reg en_d1_q;
  reg limp_d1_q;
  reg cs_low_d1_q;
  reg sck_d1_q;
  always @(posedge clock) begin
    if (rst) begin
      en_d1_q     <= 1'b0;
      limp_d1_q   <= 1'b0;
      cs_low_d1_q <= 1'b1;
      sck_d1_q    <= 1'b0;
    end else begin
      en_d1_q     <= en_s;
      limp_d1_q   <= limp_s;
      cs_low_d1_q <= cs_low_s;
      sck_d1_q    <= sck_s;
    end
  end
  wire en_rise   = en_s & ~en_d1_q;
  wire limp_fall = ~limp_s & limp_d1_q;
  wire sck_rise  = sck_s & ~sck_d1_q;
  wire sck_fall  = ~sck_s & sck_d1_q;
  wire cs_start  = ~cs_low_s & cs_low_d1_q;
  wire cs_end    = cs_low_s & ~cs_low_d1_q;

  // limp home ignores logic supply reset
  wire in_reset  = limp_s ? por_a : (por_a | por_l);

  // ==========================================================
  // mode state machine
  reg  [1:0] st_q;
  reg  [1:0] st_d;
  always @* begin
    case (st_q)
      ST_UVLO:  st_d = in_reset ? ST_UVLO : limp_s ? ST_LIMP :
                       en_s ? ST_RUN : ST_LOWIQ;
      ST_LOWIQ: st_d = limp_s ? ST_LIMP : en_s ? ST_RUN : ST_LOWIQ;
      ST_RUN:   st_d = limp_s ? ST_LIMP : en_s ? ST_RUN : ST_LOWIQ;
      ST_LIMP:  st_d = limp_s ? ST_LIMP : en_s ? ST_RUN : ST_LOWIQ;
      default:  st_d = ST_UVLO;
    endcase
    if (in_reset) begin
      st_d = ST_UVLO;
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      st_q <= ST_UVLO;
    end else begin
      st_q <= st_d;
    end
  end

  // full default reload: reset, enable edge outside limp home, lowest quiescent state, leaving limp home
  wire defaults = rst | in_reset | (en_rise & ~limp_s) | (st_q == ST_LOWIQ)
                  | limp_fall;
  // mode entries that also raise the frame error flag: leaving lockout, entering run
  wire ferr_set_evt = (st_q == ST_UVLO & st_d != ST_UVLO)
                     | (st_q != ST_RUN & st_d == ST_RUN);

  // ==========================================================
  // serial shifter
  reg [`QLSD_FRAME_BITS-1:0] shift_q;
  reg [`QLSD_CNT_W-1:0]      bits_q;
  reg [`QLSD_FRAME_BITS-1:0] cmd_q;
  reg                        pwrup_q;
  reg                        ferr_q;
  reg                        active_q;
  wire [NCH-1:0]             ovl_q;
  wire [NCH-1:0]             otp_q;
  wire                       accept = (st_q == ST_RUN) & en_s & ~limp_s;

  // frame valid: multiple of eight and at least sixteen
  function frame_ok;
    input [`QLSD_CNT_W-1:0] n;
    begin
      frame_ok = (n[2:0] == 3'h0) && (n >= `QLSD_FRAME_BITS);
    end
  endfunction

  // status word, channel n at bits 2n+1:2n, frame error on msb
  function [`QLSD_FRAME_BITS-1:0] status_word;
    input [NCH-1:0] ov;
    input [NCH-1:0] ot;
    input [NCH-1:0] ol;
    input           te;
    integer k;
    begin
      status_word = {`QLSD_FRAME_BITS{1'b0}};
      for (k = 0; k < NCH; k = k + 1) begin
        status_word[2*k+1] = ov[k] | ot[k];
        status_word[2*k]   = ol[k] | ot[k];
      end
      status_word[`QLSD_FRAME_BITS-1] = te;
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      shift_q  <= {`QLSD_FRAME_BITS{1'b0}};
      bits_q   <= {`QLSD_CNT_W{1'b0}};
      active_q <= 1'b0;
    end else if (cs_start) begin
      shift_q  <= status_word(ovl_q, otp_q, ol_s2_q, ferr_q);
      bits_q   <= {`QLSD_CNT_W{1'b0}};
      active_q <= 1'b1;
    end else if (cs_end) begin
      active_q <= 1'b0;
    end else if (active_q && sck_rise) begin
      shift_q <= {shift_q[`QLSD_FRAME_BITS-2:0], si_s};
      if (bits_q != {`QLSD_CNT_W{1'b1}}) begin
        bits_q <= bits_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // serial output, msb first, changes on falling clock
  always @(posedge clock) begin
    if (rst) begin
      serial_out_q    <= 1'b0;
      serial_out_oe_q <= 1'b0;
    end else begin
      serial_out_oe_q <= ~cs_low_s & active_q;
      if (cs_start) begin
        serial_out_q <= ferr_q;
      end else if (active_q && sck_fall) begin
        serial_out_q <= shift_q[`QLSD_FRAME_BITS-1];
      end
    end
  end

  // ==========================================================
  // command register and flags
  wire frame_done = active_q & cs_end;
  wire good_frame = frame_done & frame_ok(bits_q);
  always @(posedge clock) begin
    if (defaults) begin
      cmd_q   <= `QLSD_CMD_RESET;
      pwrup_q <= 1'b1;
    end else if (good_frame && accept) begin
      cmd_q   <= shift_q;
      pwrup_q <= 1'b0;
    end
  end
  always @(posedge clock) begin
    if (defaults) begin
      ferr_q <= 1'b1;
    end else if (ferr_set_evt || (frame_done && !frame_ok(bits_q))) begin
      ferr_q <= 1'b1;
    end else if (good_frame) begin
      ferr_q <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel fault latches
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire clr = defaults | (cmd_q[2*g+1:2*g] == `QLSD_CMD_STBY);
      qlsd_fault_filter #(
        .FILT_CYC (FILT_CYC)
      ) u_filt (
        .clock       (clock),
        .rst         (rst),
        .overload    (ovl_s[g]),
        .overtemp    (otp_s[g]),
        .clear       (clr),
        .ovl_latch_q (ovl_q[g]),
        .otp_latch_q (otp_q[g])
      );
    end
  endgenerate

  // ==========================================================
  // output drive decode
  integer i;
  reg [NCH-1:0] drv_d;
  reg [NCH-1:0] diag_d;
  reg           all_off;
  reg           all_stby;
  always @* begin
    drv_d    = {NCH{1'b0}};
    diag_d   = {NCH{1'b0}};
    all_off  = 1'b1;
    all_stby = 1'b1;
    for (i = 0; i < NCH; i = i + 1) begin
      case (cmd_q[2*i+1 -: 2])
        `QLSD_CMD_STBY:  drv_d[i] = 1'b0;
        `QLSD_CMD_INPUT: drv_d[i] = in_s[i];
        `QLSD_CMD_ON:    drv_d[i] = 1'b1;
        default:         diag_d[i] = ~pwrup_q;
      endcase
      if (cmd_q[2*i+1 -: 2] != `QLSD_CMD_OFF) begin
        all_off = 1'b0;
      end
      if (cmd_q[2*i+1 -: 2] != `QLSD_CMD_STBY) begin
        all_stby = 1'b0;
      end
      if (st_q == ST_LIMP) begin
        drv_d[i]  = in_s[i];
        diag_d[i] = 1'b0;
      end else if (st_q != ST_RUN || all_off) begin
        drv_d[i] = 1'b0;
      end
      if (ovl_q[i] || otp_q[i]) begin
        drv_d[i] = 1'b0;
      end
    end
    if (st_q != ST_RUN && st_q != ST_LIMP) begin
      diag_d = {NCH{1'b0}};
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      lowside_outputs         <= {NCH{1'b0}};
      diag_current_en         <= {NCH{1'b0}};
      lockout_state           <= 1'b1;
      limp_home_state         <= 1'b0;
      lowest_quiescent_state  <= 1'b0;
      reduced_quiescent_state <= 1'b0;
      frame_error_flag        <= 1'b1;
    end else begin
      lowside_outputs         <= drv_d;
      diag_current_en         <= diag_d;
      lockout_state           <= (st_q == ST_UVLO);
      limp_home_state         <= (st_q == ST_LIMP);
      lowest_quiescent_state  <= (st_q == ST_LOWIQ);
      reduced_quiescent_state <= (st_q == ST_RUN) & all_stby;
      frame_error_flag        <= ferr_q;
    end
  end

endmodule
`default_nettype wire
